// file: bench/chglk_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Port checker.
// ****
module chglk_regs_props import chglk_pkg::*; (
    // Clock, reset and enable.
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Register port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Conditions.
    input wire logic watchdog_expired,
    input wire logic batt_overcurrent,
    input wire logic [7:0] junction_temp_c,
    // Outputs.
    input wire logic watchdog_restart,
    input wire logic guarded_write_open,
    input wire logic otg_overload_guard_on,
    input wire logic otg_fault_retry_duty,
    input wire logic status_lamp_on,
    input wire logic battery_disconnect_switch_open,
    input wire logic charge_current_foldback,
    input wire logic thermal_regulation_flag,
    input wire logic charger_disable
);
    localparam logic [7:0] SETPT_TOP_C = CHGLK_SETPT_BASE_C
        + 8'(CHGLK_SETPT_MAX_CODE) * CHGLK_SETPT_STEP_C;
    logic [7:0] wd;
    wire logic wr_bd = ce && reg_wr && reg_addr == CHGLK_ADDR_CTRL_LOCK;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk_sys) begin
        if (wr_bd) begin
            wd <= reg_wdata;
        end
    end
    AST_WDCLR: assert property (wr_bd && reg_wdata[1:0] == 2'h1 |=> watchdog_restart)
        else $error("no restart");
    AST_KEY: assert property (wr_bd ##1 (ce && !wr_bd) |=>
        guarded_write_open == (wd[3:2] == 2'h3) && status_lamp_on == wd[7]
        && otg_fault_retry_duty == wd[5] && otg_overload_guard_on == wd[4]) else $error("bad bits");
    AST_RST: assert property (disable iff (1'b0) !rst_n |=>
        status_lamp_on && !guarded_write_open && reg_rdata == 8'h00) else $error("bad reset");
    AST_RDHOLD: assert property (ce && !reg_rd |=> $stable(reg_rdata))
        else $error("rdata moved");
    AST_UNMAP: assert property (ce && reg_rd && reg_addr < 8'hBD |=> reg_rdata == 8'h00)
        else $error("unmapped data");
    AST_FOLD: assert property (charge_current_foldback == thermal_regulation_flag)
        else $error("flag split");
    AST_TCOOL: assert property (ce && junction_temp_c <= CHGLK_SETPT_BASE_C |=>
        !thermal_regulation_flag) else $error("flag too early");
    AST_THOT: assert property (ce && junction_temp_c > SETPT_TOP_C |=>
        charge_current_foldback) else $error("no foldback");
    AST_SWOFF: assert property ((ce && !batt_overcurrent && !watchdog_expired) [*3] |=>
        !battery_disconnect_switch_open) else $error("switch open");
    AST_WDOG: assert property ((ce && watchdog_expired) [*3] |=> charger_disable)
        else $error("charger on");
endmodule
`default_nettype wire

// file: bench/tb_chglk_regs.sv
`timescale 1ns/100ps
`default_nettype none
// ****
// Bench.
// ****
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %0t: got %h want %h", $time, (a), (e)); end end
module tb_chglk_regs import chglk_pkg::*; ();
    logic clk_sys, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic watchdog_expired = 1'b0, batt_overcurrent = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, junction_temp_c = 8'h00, reg_rdata, be;
    logic signed [7:0] batt_temp_c = 8'sh19;
    logic signed [7:0] temps [4] = '{8'sh3C, 8'sh3D, 8'sh00, 8'shFF};
    logic watchdog_restart, guarded_write_open, otg_overload_guard_on, otg_fault_retry_duty;
    logic thermistor_charge_halt, status_lamp_on, battery_disconnect_switch_open;
    logic charge_current_foldback, thermal_regulation_flag, charger_disable, buck_disable;
    int n_mismatch = 0;
    int total_checks = 0;
    chglk_regs #(.OVC_CYCLES(10)) dut (.*);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
    endtask
    task automatic idle(input int n);
        repeat (n) acc(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, 1'b1, a, 8'h00);
        idle(1);
        `CHK(reg_rdata, e)
    endtask
    task automatic finish_test;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(CHGLK_ADDR_CTRL_LOCK, CHGLK_RST_CTRL_LOCK);
        rd(CHGLK_ADDR_THERM_SW, CHGLK_RST_THERM_SW);
        junction_temp_c <= 8'h73;
        idle(3);
        `CHK(thermal_regulation_flag, 1'b0)
        junction_temp_c <= 8'h74;
        idle(3);
        `CHK(thermal_regulation_flag, 1'b1)
        be = CHGLK_RST_THERM_SW;
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 1'b0, CHGLK_ADDR_CTRL_LOCK, 8'h80 | 8'(k * 5));
            acc(1'b1, 1'b0, CHGLK_ADDR_THERM_SW, 8'hC8 | 8'(k));
            `CHK(watchdog_restart, k == 1)
            if (k == 3) be = 8'hCB;
            rd(CHGLK_ADDR_THERM_SW, be);
            `CHK(guarded_write_open, k == 3)
        end
        junction_temp_c <= 8'h82;
        idle(3);
        `CHK(thermal_regulation_flag, 1'b0)
        junction_temp_c <= 8'h83;
        idle(3);
        `CHK(charge_current_foldback, 1'b1)
        batt_overcurrent <= 1'b1;
        idle(9);
        `CHK(battery_disconnect_switch_open, 1'b0)
        idle(4);
        `CHK(battery_disconnect_switch_open, 1'b1)
        acc(1'b1, 1'b0, CHGLK_ADDR_THERM_SW, 8'hCF);
        idle(3);
        `CHK(battery_disconnect_switch_open, 1'b0)
        watchdog_expired <= 1'b1;
        batt_overcurrent <= 1'b0;
        idle(3);
        `CHK({charger_disable, buck_disable, battery_disconnect_switch_open}, 3'h7)
        acc(1'b1, 1'b0, CHGLK_ADDR_THERM_SW, 8'h4F);
        idle(3);
        `CHK({charger_disable, buck_disable, battery_disconnect_switch_open}, 3'h4)
        watchdog_expired <= 1'b0;
        acc(1'b1, 1'b0, CHGLK_ADDR_CTRL_LOCK, 8'h7C);
        idle(2);
        `CHK({status_lamp_on, otg_fault_retry_duty, otg_overload_guard_on}, 3'h3)
        for (int i = 0; i < 4; i++) begin
            batt_temp_c <= temps[i];
            idle(3);
            `CHK(thermistor_charge_halt, i[0])
        end
        acc(1'b1, 1'b0, CHGLK_ADDR_CTRL_LOCK, 8'h00);
        acc(1'b1, 1'b0, CHGLK_ADDR_THERM_SW, 8'h00);
        idle(2);
        `CHK(thermistor_charge_halt, 1'b0)
        rd(CHGLK_ADDR_THERM_SW, 8'h4F);
        rd(8'h00, 8'h00);
        ce <= 1'b0;
        acc(1'b1, 1'b0, CHGLK_ADDR_CTRL_LOCK, 8'h8D);
        ce <= 1'b1;
        idle(1);
        `CHK(watchdog_restart, 1'b0)
        rd(CHGLK_ADDR_CTRL_LOCK, 8'h00);
        acc(1'b1, 1'b0, CHGLK_ADDR_CTRL_LOCK, 8'h0C);
        acc(1'b1, 1'b0, CHGLK_ADDR_THERM_SW, 8'h04);
        junction_temp_c <= 8'h55;
        idle(3);
        `CHK(thermal_regulation_flag, 1'b0)
        junction_temp_c <= 8'h56;
        idle(3);
        `CHK(charge_current_foldback, 1'b1)
        finish_test();
    end
endmodule
bind chglk_regs chglk_regs_props u_props (.*);
`default_nettype wire

// file: design/chglk_ovc_timer.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Persistence timer for battery overcurrent.
// ****************************************************************
module chglk_ovc_timer
    import chglk_pkg::*;
#(
    parameter int CYCLES = CHGLK_OVC_CYCLES
) (
    // Clock, reset and enable.
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Overcurrent condition and its persistence result.
    input wire logic over,
    output logic persisted
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic next_persisted;

    always_comb begin
        next_count = count;
        next_persisted = 1'b0;
        if (!over) begin
            next_count = '0;
        end else if (count < W'(CYCLES)) begin
            next_count = count + W'(1);
        end
        if (over && (next_count == W'(CYCLES))) begin
            next_persisted = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            count <= '0;
            persisted <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            persisted <= next_persisted;
        end
    end
endmodule
`default_nettype wire

// file: design/chglk_pkg.sv
// ****************************************************************
// Constants shared by the charger configuration register bank.
// ****************************************************************
package chglk_pkg;
    localparam logic [7:0] CHGLK_ADDR_CTRL_LOCK = 8'hBD;
    localparam logic [7:0] CHGLK_ADDR_THERM_SW = 8'hBE;
    localparam logic [7:0] CHGLK_RST_CTRL_LOCK = 8'h80;
    localparam logic [7:0] CHGLK_RST_THERM_SW = 8'h30;
    localparam int CHGLK_WDCLR_LSB = 0;
    localparam int CHGLK_KEY_LSB = 2;
    localparam int CHGLK_OTG_GUARD_BIT = 4;
    localparam int CHGLK_OTG_DUTY_BIT = 5;
    localparam int CHGLK_THM_BIT = 6;
    localparam int CHGLK_LAMP_BIT = 7;
    localparam int CHGLK_KEEP_SW_BIT = 2;
    localparam int CHGLK_SETPT_LSB = 3;
    localparam int CHGLK_WD_SW_BIT = 7;
    localparam logic [1:0] CHGLK_WDCLR_CODE = 2'h1;
    localparam logic [1:0] CHGLK_KEY_OPEN = 2'h3;
    localparam logic [7:0] CHGLK_THERM_SW_RSVD_MASK = 8'hFC;
    localparam logic [3:0] CHGLK_SETPT_MAX_CODE = 4'h9;
    localparam logic [7:0] CHGLK_SETPT_BASE_C = 8'h55;
    localparam logic [7:0] CHGLK_SETPT_STEP_C = 8'h05;
    localparam logic signed [7:0] CHGLK_BATT_HOT_C = 8'sh3C;
    localparam logic signed [7:0] CHGLK_BATT_COLD_C = 8'sh00;
    localparam int CHGLK_CLK_MHZ = 100;
    localparam int CHGLK_OVC_TIME_MS = 6;
    localparam int CHGLK_OVC_CYCLES = CHGLK_OVC_TIME_MS * 1000 * CHGLK_CLK_MHZ;
endpackage

// file: design/chglk_regs.sv
`timescale 1ns/100ps
`default_nettype none
module chglk_regs
    import chglk_pkg::*;
#(
    parameter int OVC_CYCLES = CHGLK_OVC_CYCLES
) (
    // Clock, reset and enable.
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    // Register access port.
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Measured conditions from the charger.
    input wire logic watchdog_expired,
    input wire logic batt_overcurrent,
    input wire logic signed [7:0] batt_temp_c,
    input wire logic [7:0] junction_temp_c,
    // Control and status outputs.
    output logic watchdog_restart,
    output logic guarded_write_open,
    output logic otg_overload_guard_on,
    output logic otg_fault_retry_duty,
    output logic thermistor_charge_halt,
    output logic status_lamp_on,
    output logic battery_disconnect_switch_open,
    output logic charge_current_foldback,
    output logic thermal_regulation_flag,
    output logic charger_disable,
    output logic buck_disable
);
    // ****************************************************************
    // Helper functions.
    // ****************************************************************
    function automatic logic [7:0] setpoint_c(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CHGLK_SETPT_MAX_CODE) ? CHGLK_SETPT_MAX_CODE : code;
        setpoint_c = CHGLK_SETPT_BASE_C + 8'(CHGLK_SETPT_STEP_C * {4'h0, c});
    endfunction

    // ****************************************************************
    // Register state.
    // ****************************************************************
    logic [7:0] ctrl_lock;
    logic [7:0] therm_sw;
    logic [7:0] next_ctrl_lock;
    logic [7:0] next_therm_sw;
    logic [7:0] next_reg_rdata;
    logic next_watchdog_restart;
    logic unlocked;
    logic wr_ctrl;
    logic wr_therm;

    assign unlocked = (ctrl_lock[CHGLK_KEY_LSB +: 2] == CHGLK_KEY_OPEN);
    assign wr_ctrl = reg_wr && (reg_addr == CHGLK_ADDR_CTRL_LOCK);
    assign wr_therm = reg_wr && (reg_addr == CHGLK_ADDR_THERM_SW);

    always_comb begin
        next_ctrl_lock = ctrl_lock;
        next_therm_sw = therm_sw;
        next_reg_rdata = reg_rdata;
        next_watchdog_restart = 1'b0;
        if (wr_ctrl) begin
            next_ctrl_lock = reg_wdata;
            next_watchdog_restart = (reg_wdata[CHGLK_WDCLR_LSB +: 2] == CHGLK_WDCLR_CODE);
        end
        // A locked write falls through here unchanged and flags nothing.
        if (wr_therm && unlocked) begin
            next_therm_sw = reg_wdata;
        end
        if (reg_rd) begin
            if (reg_addr == CHGLK_ADDR_CTRL_LOCK) begin
                next_reg_rdata = ctrl_lock;
            end else if (reg_addr == CHGLK_ADDR_THERM_SW) begin
                next_reg_rdata = therm_sw;
            end else begin
                next_reg_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_lock <= CHGLK_RST_CTRL_LOCK;
            therm_sw <= CHGLK_RST_THERM_SW;
            reg_rdata <= 8'h00;
            watchdog_restart <= 1'b0;
        end else if (ce) begin
            ctrl_lock <= next_ctrl_lock;
            therm_sw <= next_therm_sw;
            reg_rdata <= next_reg_rdata;
            watchdog_restart <= next_watchdog_restart;
        end
    end

    // ****************************************************************
    // Overcurrent persistence.
    // ****************************************************************
    logic ovc_persisted;

    chglk_ovc_timer #(
        .CYCLES(OVC_CYCLES)
    ) u_ovc_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .over(batt_overcurrent),
        .persisted(ovc_persisted)
    );

    // ****************************************************************
    // Charger control outputs.
    // ****************************************************************
    logic next_guarded_write_open;
    logic next_otg_guard;
    logic next_otg_duty;
    logic next_thm_halt;
    logic next_lamp;
    logic next_sw_open;
    logic next_foldback;
    logic next_thermal_regulation_flag;
    logic next_chg_dis;
    logic next_buck_dis;
    logic wd_full_off;

    assign wd_full_off = watchdog_expired && therm_sw[CHGLK_WD_SW_BIT];

    always_comb begin
        next_guarded_write_open = unlocked;
        next_otg_guard = ctrl_lock[CHGLK_OTG_GUARD_BIT];
        next_otg_duty = ctrl_lock[CHGLK_OTG_DUTY_BIT];
        next_thm_halt = ctrl_lock[CHGLK_THM_BIT]
            && ((batt_temp_c > CHGLK_BATT_HOT_C) || (batt_temp_c < CHGLK_BATT_COLD_C));
        next_lamp = ctrl_lock[CHGLK_LAMP_BIT];
        next_sw_open = (ovc_persisted && !therm_sw[CHGLK_KEEP_SW_BIT]) || wd_full_off;
        next_thermal_regulation_flag = junction_temp_c > setpoint_c(therm_sw[CHGLK_SETPT_LSB +: 4]);
        next_foldback = next_thermal_regulation_flag;
        next_chg_dis = watchdog_expired || next_thm_halt;
        next_buck_dis = wd_full_off;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            guarded_write_open <= 1'b0;
            otg_overload_guard_on <= 1'b0;
            otg_fault_retry_duty <= 1'b0;
            thermistor_charge_halt <= 1'b0;
            status_lamp_on <= CHGLK_RST_CTRL_LOCK[CHGLK_LAMP_BIT];
            battery_disconnect_switch_open <= 1'b0;
            charge_current_foldback <= 1'b0;
            thermal_regulation_flag <= 1'b0;
            charger_disable <= 1'b0;
            buck_disable <= 1'b0;
        end else if (ce) begin
            guarded_write_open <= next_guarded_write_open;
            otg_overload_guard_on <= next_otg_guard;
            otg_fault_retry_duty <= next_otg_duty;
            thermistor_charge_halt <= next_thm_halt;
            status_lamp_on <= next_lamp;
            battery_disconnect_switch_open <= next_sw_open;
            charge_current_foldback <= next_foldback;
            thermal_regulation_flag <= next_thermal_regulation_flag;
            charger_disable <= next_chg_dis;
            buck_disable <= next_buck_dis;
        end
    end
endmodule
`default_nettype wire
